// File: core/fps_pkg.sv
// shared constants, types and helpers of the flash protect/status block
package fps_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses on the apb port)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_PROT = 8'h00;  // protection register
    localparam logic [7:0] ADDR_STAT = 8'h04;  // status register
    localparam logic [7:0] ADDR_CMD = 8'h08;   // command register
    localparam logic [7:0] ADDR_TADDR = 8'h0C; // target array address
    localparam logic [7:0] ADDR_TDATA = 8'h10; // target array data
    localparam logic [7:0] ADDR_ISTAT = 8'h14; // interrupt status, w1c
    localparam logic [7:0] ADDR_IMASK = 8'h18; // interrupt mask
    localparam logic [7:0] ADDR_SEC = 8'h1C;   // security state code

    // ----------------------------------------------------------------
    // field positions and values
    // ----------------------------------------------------------------
    localparam int ST_BEF = 7;    // buffer empty flag
    localparam int ST_CCF = 6;    // command complete flag
    localparam int ST_PVIOL = 5;  // protection violation flag
    localparam int ST_ACCERR = 4; // access error flag
    localparam int ST_BLANK = 2;  // blank flag
    localparam int IRQ_DONE = 0;  // interrupt bit: all commands complete
    localparam int IRQ_PVIOL = 1; // interrupt bit: protection violation
    localparam int IRQ_ACC = 2;   // interrupt bit: access error
    localparam int IRQ_W = 3;     // interrupt register width
    localparam int PAGE_BITS = 9; // 512-byte page
    localparam logic [7:0] PROT_RST = 8'hFF;  // protection off until load
    localparam logic [1:0] SEC_RST = 2'b00;   // secure until load
    localparam logic [1:0] SEC_UNSEC = 2'b10; // unsecured code
    localparam logic [7:0] CMD_RST = 8'h00;

    // ----------------------------------------------------------------
    // command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_BLANK = 8'h05;
    localparam logic [7:0] CMD_PROG = 8'h20;
    localparam logic [7:0] CMD_BURST = 8'h25;
    localparam logic [7:0] CMD_PAGE = 8'h40;
    localparam logic [7:0] CMD_MASS = 8'h41;

    // ----------------------------------------------------------------
    // operation times (ns) and their cycle counts at 250 MHz
    // ----------------------------------------------------------------
    localparam int CLK_NS = 4;
    localparam int BLANK_NS = 400;
    localparam int PROG_NS = 800;
    localparam int BURST_NS = 400;
    localparam int PAGE_NS = 4000;
    localparam int MASS_NS = 8000;
    localparam int CNT_W = 12;
    // least times, so round up
    localparam logic [CNT_W-1:0] BLANK_CYC = CNT_W'((BLANK_NS+CLK_NS-1)/CLK_NS);
    localparam logic [CNT_W-1:0] PROG_CYC = CNT_W'((PROG_NS+CLK_NS-1)/CLK_NS);
    localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'((BURST_NS+CLK_NS-1)/CLK_NS);
    localparam logic [CNT_W-1:0] PAGE_CYC = CNT_W'((PAGE_NS+CLK_NS-1)/CLK_NS);
    localparam logic [CNT_W-1:0] MASS_CYC = CNT_W'((MASS_NS+CLK_NS-1)/CLK_NS);

    // one command as it travels from buffer to array
    typedef struct packed {
        logic [7:0] code;
        logic [15:0] addr;
        logic [7:0] data;
    } fps_cmd_t;

    // executor states, gray along idle -> run -> done
    typedef enum logic [1:0] {
        EX_IDLE = 2'b00,
        EX_RUN = 2'b01,
        EX_DONE = 2'b11
    } fps_exec_state_t;

    // recognised command code
    function automatic logic isLegal(input logic [7:0] code);
        return code == CMD_BLANK || code == CMD_PROG || code == CMD_BURST
            || code == CMD_PAGE || code == CMD_MASS;
    endfunction : isLegal

    // program or erase, i.e. anything but blank check
    function automatic logic isModify(input logic [7:0] code);
        return isLegal(code) && code != CMD_BLANK;
    endfunction : isModify

    // cycles an operation keeps the array busy
    function automatic logic [CNT_W-1:0] opCycles(input logic [7:0] code);
        case (code)
            CMD_BLANK: return BLANK_CYC;
            CMD_PROG: return PROG_CYC;
            CMD_BURST: return BURST_CYC;
            CMD_PAGE: return PAGE_CYC;
            default: return MASS_CYC;
        endcase
    endfunction : opCycles

endpackage : fps_pkg

// File: core/fps_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ns
module fps_sync #(
    parameter int W = 1
) (
    clk,
    resetn,
    asyncIn,
    syncOut
);
    input wire logic clk;
    input wire logic resetn;
    input wire logic [W-1:0] asyncIn;
    output logic [W-1:0] syncOut;

    logic [W-1:0] meta_q; // first stage, read only by the second

    // ----------------------------------------------------------------
    // two stages
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end
endmodule : fps_sync

// File: core/fps_exec.sv
// array executor: times one command and drives the array strobe
`timescale 1ns/1ns
module fps_exec (
    clk,
    resetn,
    start,
    cmdIn,
    abort,
    arrayBlank,
    busy,
    done,
    blankOk,
    arrayStart,
    arrayCmd
);
    input wire logic clk;
    input wire logic resetn;
    input wire logic start;              // take cmdIn this cycle
    input wire fps_pkg::fps_cmd_t cmdIn;
    input wire logic abort;              // stop mode, drop the operation
    input wire logic arrayBlank;         // synchronised erased indication
    output logic busy;
    output logic done;                   // one-cycle end pulse
    output logic blankOk;                // array read all erased at the end of the operation, any code
    output logic arrayStart;             // one-cycle pulse to the array
    output fps_pkg::fps_cmd_t arrayCmd;  // registered command to array

    fps_pkg::fps_exec_state_t state_q;
    logic [fps_pkg::CNT_W-1:0] cnt_q; // cycles left in the operation

    // ----------------------------------------------------------------
    // sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= fps_pkg::EX_IDLE;
            cnt_q <= '0;
            arrayStart <= 1'b0;
            arrayCmd <= '0;
            blankOk <= 1'b0;
        end else begin
            arrayStart <= 1'b0;
            case (state_q)
                fps_pkg::EX_IDLE: begin
                    if (start) begin
                        state_q <= fps_pkg::EX_RUN;
                        cnt_q <= fps_pkg::opCycles(cmdIn.code);
                        arrayCmd <= cmdIn;
                        arrayStart <= 1'b1;
                    end
                end
                fps_pkg::EX_RUN: begin
                    // abort leaves no result behind
                    if (abort) begin
                        state_q <= fps_pkg::EX_IDLE;
                    end else if (cnt_q == '0 || cnt_q == 1) begin
                        state_q <= fps_pkg::EX_DONE;
                        blankOk <= arrayBlank;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                fps_pkg::EX_DONE: begin
                    state_q <= fps_pkg::EX_IDLE;
                end
                default: begin
                    state_q <= fps_pkg::EX_IDLE;
                end
            endcase
        end
    end

    assign busy = state_q != fps_pkg::EX_IDLE;
    assign done = state_q == fps_pkg::EX_DONE;
endmodule : fps_exec

// File: core/fps_core.sv
// flash protection, status and command registers behind an apb slave
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ns

// Functional notes
// - reset loads protection from nonvolatile byte
// - only debug writes change protection register
// - select field bounds unprotected region
// - disable bit turns all protection off
// - status bits 3,1,0 read zero
// - writing one to empty flag launches
// - empty flag shows buffer room, burst only
// - complete flag: idle and buffer empty
// - protected target sets violation, drops command
// - sequence, divider, stop errors set access error
// - blank flag set when array all erased
// - blank, program, burst codes; reads zero
// - page erase and mass erase codes
// - unknown code raises access error
// - good blank check sets unsecured code
module fps_core (
    clk,
    resetn,
    paddr,
    psel,
    penable,
    pwrite,
    pwdata,
    prdata,
    pready,
    pslverr,
    nvProtByte,
    nvSecCode,
    dbgProtWe,
    dbgProtData,
    divInit,
    stopPin,
    arrayBlankPin,
    arrayStart,
    arrayCmd,
    securityCode,
    irq
);
    input wire logic clk;
    input wire logic resetn;
    input wire logic [7:0] paddr;           // byte address
    input wire logic psel;
    input wire logic penable;
    input wire logic pwrite;
    input wire logic [31:0] pwdata;
    output logic [31:0] prdata;
    output logic pready;
    output logic pslverr;
    input wire logic [7:0] nvProtByte;      // nonvolatile protection copy
    input wire logic [1:0] nvSecCode;       // nonvolatile security copy
    input wire logic dbgProtWe;             // background debug write strobe
    input wire logic [7:0] dbgProtData;
    input wire logic divInit;               // clock divider written
    input wire logic stopPin;               // stop mode request, async
    input wire logic arrayBlankPin;         // array reads all erased, async
    output logic arrayStart;
    output fps_pkg::fps_cmd_t arrayCmd;
    output logic [1:0] securityCode;
    output logic irq;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic loaded_q;              // nonvolatile copy taken
    logic [7:0] prot_q;          // protection register
    logic [1:0] sec_q;           // security state code
    logic [7:0] cmdCode_q;       // command register
    logic cmdWritten_q;          // code written since last launch
    logic [15:0] taddr_q;        // target address
    logic [7:0] tdata_q;         // target data
    logic bufFull_q;             // buffer holds a launched command
    fps_pkg::fps_cmd_t buf_q;    // the buffered command
    logic pviol_q;
    logic accerr_q;
    logic blank_q;
    logic ccfPrev_q;             // for the completion edge
    logic [fps_pkg::IRQ_W-1:0] irqStat_q;
    logic [fps_pkg::IRQ_W-1:0] irqMask_q;
    logic stopSync;
    logic blankSync;
    logic execBusy;
    logic execDone;
    logic execBlankOk;
    logic busWr;
    logic mapped;
    logic launchWr;              // write of one to the empty flag
    logic launchOk;              // launch accepted into the buffer
    logic launchPviol;
    logic launchAcc;
    logic cmdWrAcc;              // code written while buffer full
    logic stopAcc;               // stop entered mid-command
    logic xfer;                  // buffer to array
    logic ccf;
    logic [fps_pkg::IRQ_W-1:0] irqEv;
    logic [7:0] statRd;

    // ----------------------------------------------------------------
    // pin synchronisers and array executor
    // ----------------------------------------------------------------
    fps_sync #(.W(2)) uSync (
        .clk(clk),
        .resetn(resetn),
        .asyncIn({stopPin, arrayBlankPin}),
        .syncOut({stopSync, blankSync})
    );

    fps_exec uExec (
        .clk(clk),
        .resetn(resetn),
        .start(xfer),
        .cmdIn(buf_q),
        .abort(stopSync),
        .arrayBlank(blankSync),
        .busy(execBusy),
        .done(execDone),
        .blankOk(execBlankOk),
        .arrayStart(arrayStart),
        .arrayCmd(arrayCmd)
    );

    // ----------------------------------------------------------------
    // apb decode: zero wait states
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign busWr = psel && penable && pwrite;

    // known addresses
    always_comb begin
        case (paddr)
            fps_pkg::ADDR_PROT, fps_pkg::ADDR_STAT, fps_pkg::ADDR_CMD,
            fps_pkg::ADDR_TADDR, fps_pkg::ADDR_TDATA, fps_pkg::ADDR_ISTAT,
            fps_pkg::ADDR_IMASK, fps_pkg::ADDR_SEC: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // unmapped addresses answer with an error in the access phase
    assign pslverr = psel && penable && !mapped;

    // ----------------------------------------------------------------
    // launch checks
    // ----------------------------------------------------------------
    assign launchWr = busWr && paddr == fps_pkg::ADDR_STAT
        && pwdata[fps_pkg::ST_BEF];

    // access errors, listed in the order they are checked
    always_comb begin
        launchAcc = 1'b0;
        launchPviol = 1'b0;
        if (launchWr) begin
            if (bufFull_q || !cmdWritten_q) begin
                launchAcc = 1'b1;
            end else if (!fps_pkg::isLegal(cmdCode_q)) begin
                launchAcc = 1'b1;
            end else if (fps_pkg::isModify(cmdCode_q) && !divInit) begin
                launchAcc = 1'b1;
            end else if (execBusy && (cmdCode_q != fps_pkg::CMD_BURST
                    || arrayCmd.code != fps_pkg::CMD_BURST)) begin
                // only a burst behind a burst may wait in the buffer
                launchAcc = 1'b1;
            end else if (fps_pkg::isModify(cmdCode_q)
                    && !prot_q[0]
                    && (cmdCode_q == fps_pkg::CMD_MASS
                    || taddr_q[15:fps_pkg::PAGE_BITS] > prot_q[7:1])) begin
                // above the select field end lies the protected block
                launchPviol = 1'b1;
            end
        end
    end

    assign launchOk = launchWr && !launchAcc && !launchPviol;
    assign cmdWrAcc = busWr && paddr == fps_pkg::ADDR_CMD && bufFull_q;
    assign stopAcc = stopSync && (execBusy || bufFull_q);
    // buffered command moves on as soon as the array is free
    assign xfer = bufFull_q && !execBusy && !stopSync;

    // ----------------------------------------------------------------
    // protection and security, loaded once after reset release
    // ----------------------------------------------------------------
    // async reset can only take constants, so the copy is one edge later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            loaded_q <= 1'b0;
            prot_q <= fps_pkg::PROT_RST;
            sec_q <= fps_pkg::SEC_RST;
        end else begin
            loaded_q <= 1'b1;
            if (!loaded_q) begin
                prot_q <= nvProtByte;
                sec_q <= nvSecCode;
            end else begin
                // apb writes never reach here, only debug ones
                if (dbgProtWe) begin
                    prot_q <= dbgProtData;
                end
                if (execDone && arrayCmd.code == fps_pkg::CMD_BLANK
                        && execBlankOk) begin
                    sec_q <= fps_pkg::SEC_UNSEC;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // command, address and data registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmdCode_q <= fps_pkg::CMD_RST;
            cmdWritten_q <= 1'b0;
            taddr_q <= '0;
            tdata_q <= '0;
        end else begin
            if (busWr && paddr == fps_pkg::ADDR_TADDR) begin
                taddr_q <= pwdata[15:0];
            end
            if (busWr && paddr == fps_pkg::ADDR_TDATA) begin
                tdata_q <= pwdata[7:0];
            end
            if (busWr && paddr == fps_pkg::ADDR_CMD && !bufFull_q) begin
                // codes and are checked at launch
                cmdCode_q <= pwdata[7:0];
                cmdWritten_q <= 1'b1;
            end else if (launchWr) begin
                cmdWritten_q <= 1'b0; // a new sequence must start over
            end
        end
    end

    // ----------------------------------------------------------------
    // command buffer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bufFull_q <= 1'b0;
            buf_q <= '0;
        end else begin
            if (launchOk) begin
                bufFull_q <= 1'b1;
                buf_q <= '{code: cmdCode_q, addr: taddr_q, data: tdata_q};
            end else if (xfer || stopAcc) begin
                bufFull_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // error and blank flags; hardware set wins over clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pviol_q <= 1'b0;
            accerr_q <= 1'b0;
            blank_q <= 1'b0;
        end else begin
            if (launchPviol) begin
                pviol_q <= 1'b1;
            end else if (busWr && paddr == fps_pkg::ADDR_STAT
                    && pwdata[fps_pkg::ST_PVIOL]) begin
                pviol_q <= 1'b0;
            end
            if (launchAcc || cmdWrAcc || stopAcc) begin
                accerr_q <= 1'b1;
            end else if (busWr && paddr == fps_pkg::ADDR_STAT
                    && pwdata[fps_pkg::ST_ACCERR]) begin
                accerr_q <= 1'b0;
            end
            // only a blank check result or an accepted launch changes the blank flag
            if (execDone && arrayCmd.code == fps_pkg::CMD_BLANK) begin
                blank_q <= execBlankOk;
            end else if (launchOk) begin
                blank_q <= 1'b0;
            end
        end
    end

    assign ccf = !bufFull_q && !execBusy;

    // ----------------------------------------------------------------
    // interrupts: sticky status, w1c, mask gates one level output
    // ----------------------------------------------------------------
    assign irqEv = {launchAcc || cmdWrAcc || stopAcc, launchPviol,
        ccf && !ccfPrev_q};

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ccfPrev_q <= 1'b1;
            irqStat_q <= '0;
            irqMask_q <= '0;
        end else begin
            ccfPrev_q <= ccf;
            // an event in the clear cycle stays set
            if (busWr && paddr == fps_pkg::ADDR_ISTAT) begin
                irqStat_q <= (irqStat_q & ~pwdata[fps_pkg::IRQ_W-1:0])
                    | irqEv;
            end else begin
                irqStat_q <= irqStat_q | irqEv;
            end
            if (busWr && paddr == fps_pkg::ADDR_IMASK) begin
                irqMask_q <= pwdata[fps_pkg::IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // read data and outputs
    // ----------------------------------------------------------------
    always_comb begin
        statRd = '0;
        statRd[fps_pkg::ST_BEF] = !bufFull_q;
        statRd[fps_pkg::ST_CCF] = ccf;
        statRd[fps_pkg::ST_PVIOL] = pviol_q;
        statRd[fps_pkg::ST_ACCERR] = accerr_q;
        statRd[fps_pkg::ST_BLANK] = blank_q;
    end

    // read data registered in the setup cycle, valid in the access phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                fps_pkg::ADDR_PROT: prdata <= {24'h000000, prot_q};
                fps_pkg::ADDR_STAT: prdata <= {24'h000000, statRd};
                fps_pkg::ADDR_TADDR: prdata <= {16'h0000, taddr_q};
                fps_pkg::ADDR_TDATA: prdata <= {24'h000000, tdata_q};
                fps_pkg::ADDR_ISTAT: prdata <= {29'h00000000, irqStat_q};
                fps_pkg::ADDR_IMASK: prdata <= {29'h00000000, irqMask_q};
                fps_pkg::ADDR_SEC: prdata <= {30'h00000000, sec_q};
                // command register reads zero, like unmapped ones
                default: prdata <= '0;
            endcase
        end
    end

    assign securityCode = sec_q;
    assign irq = |(irqStat_q & irqMask_q);
endmodule : fps_core

// File: tb/fps_core_monitor.sv
// port assertions of the flash protect/status block
`timescale 1ns/1ns
module fps_core_monitor (clk, resetn, paddr, psel, penable, pwrite,
    prdata, pready, pslverr, arrayStart, arrayCmd);
    input wire logic clk, resetn, psel, penable, pwrite, pready, pslverr;
    input wire logic arrayStart;
    input wire logic [7:0] paddr;
    input wire logic [31:0] prdata;
    input wire fps_pkg::fps_cmd_t arrayCmd;
    logic rdSet; // read setup cycle
    assign rdSet = psel && !penable && !pwrite;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_bad_addr: assert property (psel && penable && paddr > 8'h1C
        |-> pslverr) else $error("no slave error");
    a_good_addr: assert property (psel && penable && paddr < 8'h20
        && paddr[1:0] == 2'b00 |-> !pslverr) else $error("slave error");
    a_bad_zero: assert property (rdSet && paddr > 8'h1C |=>
        prdata == 32'h0) else $error("unmapped data");
    a_cmd_zero: assert property (rdSet && paddr == 8'h08 |=>
        prdata == 32'h0) else $error("command reads back");
    a_stat_zero: assert property (rdSet && paddr == 8'h04 |=>
        prdata[3] == 1'b0 && prdata[1:0] == 2'b00) else $error("status");
    a_start_legal: assert property (arrayStart |-> arrayCmd.code
        inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("bad code");
    a_start_gap: assert property (arrayStart |=> !arrayStart [*8])
        else $error("start too soon");
    c_mass: cover property (arrayStart && arrayCmd.code == 8'h41);
    c_blank: cover property (arrayStart && arrayCmd.code == 8'h05);
    c_err: cover property (psel && penable && pslverr);
endmodule : fps_core_monitor
bind fps_core fps_core_monitor uMon (.clk(clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .arrayStart(arrayStart), .arrayCmd(arrayCmd));

// File: tb/test_flash_protect_status_command.sv
// self-checking bench of the flash protect/status block
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_flash_protect_status_command;
    logic clk, resetn, psel, penable, pwrite, pready, pslverr, irq;
    logic dbgProtWe, divInit, stopPin, arrayBlankPin, arrayStart;
    logic [7:0] paddr, nvProtByte, dbgProtData, prot;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] nvSecCode, securityCode;
    logic [64:0] rdQ[$]; // {slave error, mask, data}
    logic [31:0] cmdQ[$];
    logic [31:0] cx;
    logic [7:0] codes[5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    fps_pkg::fps_cmd_t arrayCmd;
    int errors, checks, cycles;
    fps_core dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .nvProtByte(nvProtByte),
        .nvSecCode(nvSecCode), .dbgProtWe(dbgProtWe),
        .dbgProtData(dbgProtData), .divInit(divInit), .stopPin(stopPin),
        .arrayBlankPin(arrayBlankPin), .arrayStart(arrayStart),
        .arrayCmd(arrayCmd), .securityCode(securityCode), .irq(irq));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // watcher: oldest note against each finished read or array start
    always @(posedge clk) begin
        cycles++;
        if (psel && penable && pready && !pwrite) begin
            `CHK({pslverr, prdata & rdQ[0][63:32]}, {rdQ[0][64], rdQ[0][31:0]})
            void'(rdQ.pop_front());
        end
        if (arrayStart) begin
            cx = cmdQ.pop_front();
            `CHK(arrayCmd, cx)
        end
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (!pready);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rdx(input logic [7:0] a, input logic [31:0] e, m, input logic x);
        rdQ.push_back({x, m, e & m});
        apb(1'b0, a, 32'h0);
    endtask : rdx
    // address, data, code, then launch
    task go(input logic [7:0] c, input logic [15:0] a, input logic q);
        logic [31:0] d;
        d = $urandom;
        if (q) cmdQ.push_back({c, a, d[7:0]});
        apb(1'b1, 8'h0C, {16'h0, a});
        apb(1'b1, 8'h10, d);
        apb(1'b1, 8'h08, {24'h0, c});
        apb(1'b1, 8'h04, 32'h80);
    endtask : go
    task idle;
        rd = 32'h0;
        for (int n = 0; n < 3000 && rd[7:6] != 2'b11; n++) rdx(8'h04, 0, 0, 0);
    endtask : idle
    task dbg(input logic [7:0] v);
        @(posedge clk);
        dbgProtWe <= 1'b1;
        dbgProtData <= v;
        @(posedge clk);
        dbgProtWe <= 1'b0;
    endtask : dbg
    task irqIs(input logic [31:0] m, input logic e);
        apb(1'b1, 8'h18, m);
        @(posedge clk);
        `CHK(irq, e)
    endtask : irqIs
    task close_out;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    initial begin
        {psel, penable, pwrite, paddr, pwdata, dbgProtWe, dbgProtData} = '0;
        {resetn, stopPin, nvSecCode} = '0;
        {divInit, arrayBlankPin} = 2'b11;
        void'($urandom(32'h31C79BC6));
        prot = {7'($urandom_range(126, 1)), 1'b0};
        nvProtByte = prot;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        rdx(8'h00, prot, 32'hFF, 1'b0);
        apb(1'b1, 8'h00, ~prot);
        rdx(8'h00, prot, 32'hFF, 1'b0);
        dbg(8'h01);
        rdx(8'h00, 32'h1, 32'hFF, 1'b0);
        apb(1'b1, 8'h04, 32'h4F);
        rdx(8'h04, 32'hC0, 32'hFF, 1'b0);
        rdx(8'h08, 32'h0, '1, 1'b0);
        rdx(8'h40, 32'h0, '1, 1'b1);
        $display("registers done");
        foreach (codes[i]) begin
            go(codes[i], 16'hFE00, 1'b1);
            idle();
            rdx(8'h04, i ? 32'hC0 : 32'hC4, 32'hFF, 1'b0);
        end
        `CHK(securityCode, fps_pkg::SEC_UNSEC)
        go(8'h25, 16'h0100, 1'b1);
        go(8'h25, 16'h0101, 1'b1);
        rdx(8'h04, 32'h0, 32'hC0, 1'b0);
        apb(1'b1, 8'h08, 32'h20);
        idle();
        rdx(8'h04, 32'hD0, 32'hFF, 1'b0);
        apb(1'b1, 8'h04, 32'h10);
        arrayBlankPin <= 1'b0;
        go(8'h05, 16'h0, 1'b1);
        idle();
        rdx(8'h04, 32'hC0, 32'hFF, 1'b0);
        $display("commands done");
        go(8'h33, 16'h0, 1'b0);
        idle();
        rdx(8'h04, 32'h10, 32'h3B, 1'b0);
        apb(1'b1, 8'h04, 32'h10);
        divInit <= 1'b0;
        go(8'h40, 16'h0, 1'b0);
        idle();
        rdx(8'h04, 32'h10, 32'h3B, 1'b0);
        apb(1'b1, 8'h04, 32'h10);
        divInit <= 1'b1;
        go(8'h40, 16'h0, 1'b1);
        stopPin <= 1'b1;
        repeat (4) @(posedge clk);
        stopPin <= 1'b0;
        idle();
        rdx(8'h04, 32'h10, 32'h3B, 1'b0);
        apb(1'b1, 8'h04, 32'h10);
        dbg(prot);
        go(8'h20, {prot[7:1], 9'h1FF}, 1'b1);
        idle();
        go(8'h20, 16'hFE00, 1'b0);
        idle();
        rdx(8'h04, 32'h20, 32'h3B, 1'b0);
        irqIs(32'h2, 1'b1);
        irqIs(32'h0, 1'b0);
        apb(1'b1, 8'h14, 32'h7);
        irqIs(32'h7, 1'b0);
        apb(1'b1, 8'h04, 32'h20);
        rdx(8'h04, 32'h0, 32'h3B, 1'b0);
        $display("errors done");
        close_out();
    end
endmodule : test_flash_protect_status_command
